// ==== include/pegp_consts.svh ====
// Offsets, reset values and fixed figures of the port block
`ifndef PEGP_CONSTS_SVH
`define PEGP_CONSTS_SVH

`define PEGP_OFF_DATA 8'h00
`define PEGP_OFF_DIR 8'h04
`define PEGP_OFF_PULL 8'h08
`define PEGP_OFF_SLEW 8'h0c
`define PEGP_OFF_ISEL 8'h10
`define PEGP_OFF_ESEL 8'h14

`define PEGP_RST_DATA 8'h00
`define PEGP_RST_DIR 8'h00
`define PEGP_RST_PULL 8'h00
`define PEGP_RST_SLEW 8'h00
`define PEGP_RST_ISEL 8'h00
`define PEGP_RST_ESEL 8'h00

`define PEGP_IO_BIT 1
`define PEGP_IO_MASK 8'h02
`define PEGP_SYNC_STAGES 2

`endif

// ==== include/pegp_pkg.sv ====
// Types shared by the port block files
package pegp_pkg;

	// Per-pin configuration handed to a pad cell
	typedef struct packed {
		logic dir;
		logic data;
		logic pull;
		logic slew;
		logic isel;
		logic esel;
	} pegp_cfg_t;

	// Per-pin pad controls
	typedef struct packed {
		logic out;
		logic oe_n;
		logic pu;
		logic pd;
		logic slew;
	} pegp_pad_t;

	// Bus slave phase, one-hot
	typedef enum logic [1:0] {
		PEGP_IDLE = 2'b01,
		PEGP_ANSWER = 2'b10
	} pegp_phase_t;

endpackage

// ==== hw/pegp_sync.sv ====
// Two-stage level synchroniser for the pin inputs
`timescale 1ns/1ps
module pegp_sync
	import pegp_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	// First stage feeds only the second
	logic [WIDTH-1:0] meta;

	// Two flops in the bus clock domain
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end

endmodule

// ==== hw/pegp_pad_cell.sv ====
// Registered pad control for one port pin
`timescale 1ns/1ps
module pegp_pad_cell
	import pegp_pkg::*;
#(
	parameter bit INPUT_ONLY = 1'b0
) (
	input wire logic pclk,
	input wire logic presetn,
	input pegp_cfg_t cfg,
	output pegp_pad_t pad
);

	logic drive;
	logic pull_on;
	logic irq_pull;

	// Input-only pin never drives, whatever its bits say
	assign drive = cfg.dir & ~INPUT_ONLY;
	// Pulls only on inputs
	assign pull_on = cfg.pull & ~drive;
	// Pull-down only with pin and edge select both set
	assign irq_pull = cfg.isel & cfg.esel;

	// Reset leaves a high-impedance input, no pull
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pad.out <= 1'b0;
			pad.oe_n <= 1'b1;
			pad.pu <= 1'b0;
			pad.pd <= 1'b0;
			pad.slew <= 1'b0;
		end else begin
			pad.out <= cfg.data & drive;
			pad.oe_n <= ~drive;
			pad.pu <= pull_on & ~irq_pull;
			pad.pd <= pull_on & irq_pull;
			pad.slew <= cfg.slew & drive;
		end
	end

endmodule

// ==== hw/pegp_port.sv ====
// Eight-bit general-purpose port with an APB register slave
//
// Overview of operation
// (R1) Input pin: data read returns the pin level.
// (R2) Output pin: data read returns the last written value.
// (R3) Data writes update all eight stored bits regardless of direction.
// (R4) Output pins drive their stored data bit.
// (R5) Reset clears data; pins become undriven inputs, pulls off.
// (R6) Direction 0: driver off, read pin; 1: driver on, read stored bit.
// (R7) Bit 1 reads always return the pin level.
// (R8) Direction and slew bits at position 1 do nothing; pin never driven.
// (R9) Pull-enable 1 turns the pin's pull device on, 0 off.
// (R10) Output pins ignore pull-enable; pulls are off.
// (R11) Pull-down only with pin select and edge select set; else pull-up.
// (R12) Slew bit switches slew control; no effect on inputs.
// (R13) Software should set slew bits explicitly, not trust reset values.
// (R14) Pin levels pass a two-stage synchroniser before the read path.
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "pegp_consts.svh"
module pegp_port
	import pegp_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int PINS = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [PINS-1:0] pin_in,
	output logic [PINS-1:0] pin_out,
	output logic [PINS-1:0] pin_oe_n,
	output logic [PINS-1:0] pull_up_en,
	output logic [PINS-1:0] pull_down_en,
	output logic [PINS-1:0] slew_ctl
);

	// Software-visible registers
	logic [PINS-1:0] port_pin_data;
	logic [PINS-1:0] port_pin_direction;
	logic [PINS-1:0] port_pull_enable;
	logic [PINS-1:0] port_slew_enable;
	logic [PINS-1:0] irq_pin_select;
	logic [PINS-1:0] irq_edge_select;

	// Bus phase and decode
	pegp_phase_t phase;
	pegp_phase_t next_phase;
	logic setup;
	logic wr_done;
	logic hit_data;
	logic hit_dir;
	logic hit_pull;
	logic hit_slew;
	logic hit_isel;
	logic hit_esel;
	logic mapped;
	logic lane0;

	// Pin side
	logic [PINS-1:0] pin_sync;
	logic [PINS-1:0] io_mask;
	logic [PINS-1:0] drv_mask;
	logic [PINS-1:0] read_view;
	logic [31:0] next_prdata;
	pegp_cfg_t [PINS-1:0] cfg;
	pegp_pad_t [PINS-1:0] pad;

	// Pin levels cross in through two flops
	pegp_sync #(
		.WIDTH(PINS)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d(pin_in),
		.q(pin_sync)
	); // R14

	// Mask of the input-only position
	assign io_mask = PINS'(`PEGP_IO_MASK);
	// Pins whose driver is on
	assign drv_mask = port_pin_direction & ~io_mask; // R6 R8

	// Read view: stored bit where driven, else pin level
	always_comb begin
		for (int i = 0; i < PINS; i++) begin
			if (drv_mask[i]) begin
				read_view[i] = port_pin_data[i]; // R2 R6
			end else begin
				read_view[i] = pin_sync[i]; // R1 R7
			end
		end
	end

	// Address decode; low two bits must be zero
	assign hit_data = paddr == ADDR_W'(`PEGP_OFF_DATA);
	assign hit_dir = paddr == ADDR_W'(`PEGP_OFF_DIR);
	assign hit_pull = paddr == ADDR_W'(`PEGP_OFF_PULL);
	assign hit_slew = paddr == ADDR_W'(`PEGP_OFF_SLEW);
	assign hit_isel = paddr == ADDR_W'(`PEGP_OFF_ISEL);
	assign hit_esel = paddr == ADDR_W'(`PEGP_OFF_ESEL);
	assign mapped = hit_data | hit_dir | hit_pull | hit_slew | hit_isel | hit_esel;

	// Setup cycle of a transfer
	assign setup = psel & ~penable;
	// Data sits in byte lane 0 only
	assign lane0 = pstrb[0];
	// Write lands on the edge that sees pready high
	assign wr_done = psel & penable & pready & pwrite & mapped & lane0;

	// Phase sequencing: one wait-free access cycle
	always_comb begin
		case (phase)
			PEGP_IDLE: begin
				if (setup) begin
					next_phase = PEGP_ANSWER;
				end else begin
					next_phase = PEGP_IDLE;
				end
			end
			PEGP_ANSWER: begin
				next_phase = PEGP_IDLE;
			end
			default: begin
				next_phase = PEGP_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase <= PEGP_IDLE;
		end else begin
			phase <= next_phase;
		end
	end

	// Ready raised for exactly the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= (phase == PEGP_IDLE) & setup;
		end
	end

	// Unmapped or misaligned address answers with an error
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else if ((phase == PEGP_IDLE) & setup) begin
			pslverr <= ~mapped;
		end else begin
			pslverr <= 1'b0;
		end
	end

	// Read data chosen in setup, upper bits zero
	always_comb begin
		next_prdata = 32'h0000_0000;
		if (!pwrite) begin
			case (1'b1)
				hit_data: next_prdata[PINS-1:0] = read_view; // R1 R2 R7
				hit_dir: next_prdata[PINS-1:0] = port_pin_direction;
				hit_pull: next_prdata[PINS-1:0] = port_pull_enable;
				hit_slew: next_prdata[PINS-1:0] = port_slew_enable;
				hit_isel: next_prdata[PINS-1:0] = irq_pin_select;
				hit_esel: next_prdata[PINS-1:0] = irq_edge_select;
				default: next_prdata = 32'h0000_0000;
			endcase
		end
	end

	// Read data held through the access cycle only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if ((phase == PEGP_IDLE) & setup) begin
			prdata <= next_prdata;
		end else begin
			prdata <= 32'h0000_0000;
		end
	end

	// Data register: every bit latched, whatever the direction
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_pin_data <= PINS'(`PEGP_RST_DATA); // R5
		end else if (wr_done & hit_data) begin
			port_pin_data <= pwdata[PINS-1:0]; // R3
		end
	end

	// Direction register; bit 1 stored but ignored by the pad
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_pin_direction <= PINS'(`PEGP_RST_DIR); // R5
		end else if (wr_done & hit_dir) begin
			port_pin_direction <= pwdata[PINS-1:0];
		end
	end

	// Pull enable register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_pull_enable <= PINS'(`PEGP_RST_PULL); // R5
		end else if (wr_done & hit_pull) begin
			port_pull_enable <= pwdata[PINS-1:0]; // R9
		end
	end

	// Slew register; reset value may not be trusted by software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_slew_enable <= PINS'(`PEGP_RST_SLEW);
		end else if (wr_done & hit_slew) begin
			port_slew_enable <= pwdata[PINS-1:0]; // R12
		end
	end

	// Pin and edge select steer only the pull direction here
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_pin_select <= PINS'(`PEGP_RST_ISEL);
			irq_edge_select <= PINS'(`PEGP_RST_ESEL);
		end else if (wr_done & hit_isel) begin
			irq_pin_select <= pwdata[PINS-1:0]; // R11
		end else if (wr_done & hit_esel) begin
			irq_edge_select <= pwdata[PINS-1:0]; // R11
		end
	end

	// One registered pad cell per pin
	for (genvar g = 0; g < PINS; g++) begin : g_pad
		assign cfg[g].dir = port_pin_direction[g];
		assign cfg[g].data = port_pin_data[g];
		assign cfg[g].pull = port_pull_enable[g];
		assign cfg[g].slew = port_slew_enable[g];
		assign cfg[g].isel = irq_pin_select[g];
		assign cfg[g].esel = irq_edge_select[g];
		pegp_pad_cell #(
			.INPUT_ONLY(g == `PEGP_IO_BIT)
		) u_cell (
			.pclk(pclk),
			.presetn(presetn),
			.cfg(cfg[g]),
			.pad(pad[g])
		); // R4 R8 R9 R10 R11 R12
		assign pin_out[g] = pad[g].out;
		assign pin_oe_n[g] = pad[g].oe_n;
		assign pull_up_en[g] = pad[g].pu;
		assign pull_down_en[g] = pad[g].pd;
		assign slew_ctl[g] = pad[g].slew;
	end

	// Checks on the bus answer, the data register, the synchroniser and the pads
	sequence s_setup;
		psel && !penable && (phase == PEGP_IDLE);
	endsequence

	sequence s_rd_data;
		s_setup and (hit_data && !pwrite);
	endsequence

	sequence s_wr_data;
		psel && penable && pready && pwrite && hit_data && pstrb[0];
	endsequence

	a_answer_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
		s_setup |=> pready ##1 !pready)
	else $error("pready not a single cycle after setup");

	a_read_stored_bit: assert property (@(posedge pclk) disable iff (!presetn) // R2
		s_rd_data |=> ((prdata[PINS-1:0] & $past(drv_mask)) == ($past(port_pin_data) & $past(drv_mask))))
	else $error("driven pin read did not return stored bit");

	a_read_pin_level: assert property (@(posedge pclk) disable iff (!presetn) // R1
		s_rd_data |=> ((prdata[PINS-1:0] & ~$past(drv_mask)) == ($past(pin_sync) & ~$past(drv_mask))))
	else $error("input pin read did not return pin level");

	a_read_io_bit: assert property (@(posedge pclk) disable iff (!presetn) // R7
		s_rd_data |=> prdata[`PEGP_IO_BIT] == $past(pin_sync[`PEGP_IO_BIT]))
	else $error("input-only bit read not the pin level");

	a_write_all_bits: assert property (@(posedge pclk) disable iff (!presetn) // R3
		s_wr_data |=> port_pin_data == $past(pwdata[PINS-1:0]))
	else $error("data write did not update all bits");

	a_drive_level: assert property (@(posedge pclk) disable iff (!presetn) // R4
		##1 pin_out == $past(port_pin_data & drv_mask))
	else $error("output level differs from stored bit");

	a_driver_enable: assert property (@(posedge pclk) disable iff (!presetn) // R6
		##1 pin_oe_n == ~$past(drv_mask))
	else $error("driver enable does not follow direction");

	a_io_never_driven: assert property (@(posedge pclk) disable iff (!presetn) // R8
		pin_oe_n[`PEGP_IO_BIT] && !slew_ctl[`PEGP_IO_BIT])
	else $error("input-only pin driven or slewed");

	a_pull_gate: assert property (@(posedge pclk) disable iff (!presetn) // R10
		##1 (pull_up_en | pull_down_en) == $past(port_pull_enable & ~drv_mask))
	else $error("pull state wrong for direction or enable");

	a_pull_down_sel: assert property (@(posedge pclk) disable iff (!presetn) // R11
		##1 pull_down_en == $past(port_pull_enable & ~drv_mask & irq_pin_select & irq_edge_select))
	else $error("pull-down without both selects");

	a_slew_gate: assert property (@(posedge pclk) disable iff (!presetn) // R12
		##1 slew_ctl == $past(port_slew_enable & drv_mask))
	else $error("slew control on a non-driven pin");

	// Attempts begun on the release edge would see flops still cleared
	a_pin_sync: assert property (@(posedge pclk) disable iff (!presetn) // R14
		presetn |-> ##2 pin_sync == $past(pin_in, 2))
	else $error("pin level not two cycles late");

	a_no_drive_reset: assert property (@(posedge pclk) disable iff (!presetn) // R5
		(port_pin_direction == '0) |=> (pin_oe_n == '1) && (pin_out == '0))
	else $error("pin driven with all directions input");

endmodule

// ==== verification/pegp_pin_model.sv ====
// Model of the external circuitry on the eight port pins
`timescale 1ns/1ps
module pegp_pin_model (
	input wire logic pclk,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe_n,
	input wire logic [7:0] pull_up_en,
	input wire logic [7:0] pull_down_en,
	input wire logic [7:0] ext_en,
	input wire logic [7:0] ext_val,
	output logic [7:0] pin_in
);
	logic [7:0] lvl = 8'h00;

	// Resolve each wire: port driver, then outside driver, then pull
	// A wire nobody holds toggles, so a stale level never reads as valid
	always @(posedge pclk) begin
		for (int i = 0; i < 8; i++) begin
			if (!pin_oe_n[i]) lvl[i] <= pin_out[i];
			else if (ext_en[i]) lvl[i] <= ext_val[i];
			else if (pull_up_en[i]) lvl[i] <= 1'b1;
			else if (pull_down_en[i]) lvl[i] <= 1'b0;
			else lvl[i] <= ~lvl[i];
		end
	end
	assign pin_in = lvl;
endmodule

// ==== verification/test_eight_bit_port_e_gpio.sv ====
// Self-checking bench for the eight-bit port block
`timescale 1ns/1ps
`include "pegp_consts.svh"
module test_eight_bit_port_e_gpio;
	typedef struct packed {
		logic [7:0] dir, data, pull, slew, isel, esel, xen, xval;
		logic [7:0] oe_n, out, pu, pd, slw, rd;
	} pegp_row_t;
	// Settings, outside drive, then expected pads and data read
	localparam pegp_row_t ROWS [3] = '{
		'{8'hff, 8'ha7, 8'hff, 8'hff, 8'h00, 8'h00, 8'h02, 8'h00, 8'h02, 8'ha5, 8'h02, 8'h00, 8'hfd, 8'ha5},
		'{8'h00, 8'h5a, 8'hff, 8'hff, 8'hf0, 8'hcc, 8'h00, 8'h00, 8'hff, 8'h00, 8'h3f, 8'hc0, 8'h00, 8'h3f},
		'{8'h0f, 8'h3c, 8'hf0, 8'h00, 8'hff, 8'hff, 8'hf2, 8'h96, 8'hf2, 8'h0c, 8'h00, 8'hf0, 8'h00, 8'h9e}
	};
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'h0;
	logic [31:0] prdata;
	logic pready, pslverr;
	logic [7:0] pin_in, pin_out, pin_oe_n, pull_up_en, pull_down_en, slew_ctl;
	// Pins held low from outside until the table takes over, so reads are known
	logic [7:0] ext_en = 8'hff;
	logic [7:0] ext_val = 8'h00;
	logic [31:0] rd;
	logic er;
	int err_total = 0;
	int n_compared = 0;

	// Bus clock, 4 ns period
	always #2 pclk = ~pclk;

	pegp_port DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready,
		.pslverr, .pin_in, .pin_out, .pin_oe_n, .pull_up_en, .pull_down_en, .slew_ctl);
	pegp_pin_model pins (.pclk, .pin_out, .pin_oe_n, .pull_up_en, .pull_down_en, .ext_en, .ext_val, .pin_in);

	// Print counts and verdict, then stop
	task automatic complete_run;
		$display("Mismatches %0d of %0d compares", err_total, n_compared);
		if (err_total == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Compare seen against expected
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer; a spare edge after release keeps drivers apart
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
		output logic [31:0] r, output logic e);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			err_total++;
			complete_run();
		end
		@(posedge pclk);
	endtask

	initial begin
		repeat (3) @(posedge pclk);
		chk({24'h0, pin_oe_n}, 32'hff);
		chk({24'h0, pin_out | pull_up_en | pull_down_en | slew_ctl}, 32'h0);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int a = 0; a < 16; a += 4) begin
			xfer(1'b0, 8'(a), 8'h00, 4'h0, rd, er);
			chk(rd, 32'h0);
		end
		// Table of configurations; slew always set explicitly
		for (int i = 0; i < 3; i++) begin
			xfer(1'b1, `PEGP_OFF_SLEW, ROWS[i].slew, 4'h1, rd, er);
			xfer(1'b1, `PEGP_OFF_PULL, ROWS[i].pull, 4'h1, rd, er);
			xfer(1'b1, `PEGP_OFF_ISEL, ROWS[i].isel, 4'h1, rd, er);
			xfer(1'b1, `PEGP_OFF_ESEL, ROWS[i].esel, 4'h1, rd, er);
			xfer(1'b1, `PEGP_OFF_DATA, ROWS[i].data, 4'h1, rd, er);
			xfer(1'b1, `PEGP_OFF_DIR, ROWS[i].dir, 4'h1, rd, er);
			ext_en <= ROWS[i].xen;
			ext_val <= ROWS[i].xval;
			repeat (4) @(posedge pclk);
			chk({24'h0, pin_oe_n}, {24'h0, ROWS[i].oe_n});
			chk({24'h0, pin_out}, {24'h0, ROWS[i].out});
			chk({24'h0, pull_up_en}, {24'h0, ROWS[i].pu});
			chk({24'h0, pull_down_en}, {24'h0, ROWS[i].pd});
			chk({24'h0, slew_ctl}, {24'h0, ROWS[i].slw});
			xfer(1'b0, `PEGP_OFF_DATA, 8'h00, 4'h0, rd, er);
			chk(rd, {24'h0, ROWS[i].rd});
			xfer(1'b0, `PEGP_OFF_SLEW, 8'h00, 4'h0, rd, er);
			chk(rd, {24'h0, ROWS[i].slew});
		end
		// Data stored while input, driven once direction flips
		xfer(1'b1, `PEGP_OFF_DIR, 8'h00, 4'h1, rd, er);
		xfer(1'b1, `PEGP_OFF_DATA, 8'h5a, 4'h1, rd, er);
		xfer(1'b1, `PEGP_OFF_DIR, 8'hff, 4'h1, rd, er);
		repeat (2) @(posedge pclk);
		chk({24'h0, pin_out}, 32'h58);
		// Strobe off, misaligned and unmapped accesses change nothing
		xfer(1'b1, `PEGP_OFF_DIR, 8'h00, 4'h0, rd, er);
		xfer(1'b1, 8'h05, 8'h00, 4'h1, rd, er);
		chk({31'h0, er}, 32'h1);
		xfer(1'b0, 8'h18, 8'h00, 4'h0, rd, er);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		xfer(1'b0, `PEGP_OFF_DIR, 8'h00, 4'h0, rd, er);
		chk(rd, 32'hff);
		// Second reset in mid-run undrives every pin
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk({24'h0, pin_oe_n}, 32'hff);
		chk({24'h0, pin_out | pull_up_en | pull_down_en | slew_ctl}, 32'h0);
		presetn <= 1'b1;
		@(posedge pclk);
		xfer(1'b0, `PEGP_OFF_DIR, 8'h00, 4'h0, rd, er);
		chk(rd, 32'h0);
		// Cleared data shows once pins are turned to outputs
		xfer(1'b1, `PEGP_OFF_DIR, 8'hff, 4'h1, rd, er);
		xfer(1'b0, `PEGP_OFF_DATA, 8'h00, 4'h0, rd, er);
		chk(rd, 32'h02);
		chk({24'h0, pin_out}, 32'h0);
		complete_run();
	end
endmodule
